// ===== src/six_bit_port_defs.vh
// Register map, field positions and reset values of the six-bit port
`ifndef SIX_BIT_PORT_DEFS_VH
`define SIX_BIT_PORT_DEFS_VH

// Byte offsets within the block (haddr[7:0])
`define OFF_PORT_PIN_LEVELS    8'h00
`define OFF_PORT_DIRECTION     8'h04
`define OFF_ANALOG_SELECT_LOW  8'h08
`define OFF_ANALOG_SELECT_HIGH 8'h0c
`define OFF_PULLUP_ENABLE      8'h10
`define OFF_CHANGE_IRQ_ENABLE  8'h14
`define OFF_INTERRUPT_CONTROL  8'h18
`define OFF_OPTION             8'h1c
`define OFF_CONFIG             8'h20

// Field positions
`define INTERRUPT_CONTROL_REG_CHANGE_FLAG_BIT 0
`define OPTION_PULLUP_DIS_BIT  0
`define CONFIG_MASTER_CLEAR_EN_BIT     0
`define CONFIG_OSC_PINS_BIT    1
`define PIN_THREE              3

// Reset values
`define RST_PORT_LATCH         6'h00
`define RST_PORT_DIRECTION     6'h3f
`define RST_ANALOG_LOW         8'hff
`define RST_ANALOG_HIGH        4'hf
`define RST_PULLUP_ENABLE      6'h37
`define RST_CHANGE_IRQ_ENABLE  6'h00
`define RST_OPTION             1'h1
`define RST_CONFIG             2'h0

// Masks
`define MASK_OSC_PINS          6'h30
`define MASK_PIN_THREE         6'h08
`define MASK_HAS_PULLUP        6'h37

// AHB-Lite encodings
`define HTRANS_NONSEQ_BIT      1
`define HRESP_OKAY             1'b0

`endif

// ===== src/six_bit_port.v
// Six-bit bidirectional port with analog select, weak pull-ups and change detect
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Port read returns pin levels, bits 7:6 zero
// - Direction 1 tri-states pin, 0 drives latch
// - Pin three direction always reads 1
// - Oscillator modes force pins 5:4 to input
// - Analog select makes digital reads return 0
// - Analog select leaves output driver unchanged
// - Analog select kills pull-up and change detect
// - Low analog select: eight channel bits
// - High analog select: bits 3:0, rest zero
// - Per-pin pull-up enables except pin three
// - Output pins never get pull-up
// - Global pull-up disable set at power-on
// - Pin three pull-up follows master clear
// - Per-pin change enables, cleared at power-on
// - Mismatch against last-read latch sets flag
// - Change flag wakes core from sleep
// - Flag re-sets while mismatch persists
// - Last-read latch survives warm resets
// - Change at read sample is still flagged
// - Port writes overwrite latch, read-modify-write
// - Read gives pins, write loads latch
// - Pin three reads 0 under master clear
module six_bit_port #(
  parameter PINS = 6
) (
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              warm_reset,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire [31:0]       hrdata,
  output wire              hreadyout,
  output wire              hresp,
  input  wire [PINS-1:0]   pin_in,
  output wire [PINS-1:0]   pin_out,
  output wire [PINS-1:0]   pin_oe,
  output wire [PINS-1:0]   pullup_on,
  output wire [PINS-1:0]   digital_in_en,
  output wire              change_irq_flag,
  output wire              wake_req
);

  `include "six_bit_port_defs.vh"

  // Register state
  reg [PINS-1:0] port_latch_reg;
  reg [PINS-1:0] port_direction_reg;
  reg [7:0]      analog_select_low_reg;
  reg [3:0]      analog_select_high_reg;
  reg [PINS-1:0] pullup_enable_reg;
  reg [PINS-1:0] change_irq_enable_reg;
  reg            change_flag_reg;
  reg            global_pullup_disable_reg;
  reg [1:0]      config_reg;
  reg [PINS-1:0] last_read_reg;

  // Pin synchroniser and filtered level
  reg [PINS-1:0] sync1_reg;
  reg [PINS-1:0] sync2_reg;
  reg [PINS-1:0] sync3_reg;
  reg [PINS-1:0] pin_level_reg;

  // Bus state
  reg            wr_pending_reg;
  reg [7:0]      wr_addr_reg;
  reg [31:0]     hrdata_reg;
  reg            hreadyout_reg;
  reg            hresp_reg;

  // Pin drive outputs
  reg [PINS-1:0] pin_out_reg;
  reg [PINS-1:0] pin_oe_reg;
  reg [PINS-1:0] pullup_on_reg;
  reg [PINS-1:0] digital_in_en_reg;
  reg            wake_req_reg;

  // Forces oscillator pins to read 1 when they serve the oscillator
  function [PINS-1:0] osc_force;
    input [PINS-1:0] v;
    input            osc_mode;
    begin
      osc_force = osc_mode ? (v | `MASK_OSC_PINS) : v;
    end
  endfunction

  // Zero-extends a six-bit field into a bus word
  function [31:0] word6;
    input [PINS-1:0] v;
    begin
      word6 = {26'h0000000, v};
    end
  endfunction

  // Data-phase write strobe for one register offset
  function wr_hit;
    input       pending;
    input [7:0] addr;
    input [7:0] offset;
    begin
      wr_hit = pending & (addr == offset);
    end
  endfunction

  wire           master_clear_en   = config_reg[`CONFIG_MASTER_CLEAR_EN_BIT];
  wire           osc_pins  = config_reg[`CONFIG_OSC_PINS_BIT];

  // Pins 0,1,2,4 map to channels 0,1,2,3; pins 3 and 5 have no analog role
  wire [PINS-1:0] analog_pin = {1'b0, analog_select_low_reg[3], 1'b0,
                                analog_select_low_reg[2:0]};

  wire [PINS-1:0] direction_eff;
  assign direction_eff = osc_force(port_direction_reg | `MASK_PIN_THREE,
                                   osc_pins);

  // Digital view of the pins, masked by the low analog select
  wire [PINS-1:0] pin_digital;
  assign pin_digital = pin_level_reg & ~analog_pin;

  wire [PINS-1:0] port_read_value;
  assign port_read_value = master_clear_en ? (pin_digital & ~`MASK_PIN_THREE)
                                   : pin_digital;

  // Analog pins are excluded from change detection
  wire [PINS-1:0] change_active = change_irq_enable_reg & ~analog_pin;
  wire            mismatch = |((port_read_value ^ last_read_reg)
                               & change_active);

  wire [PINS-1:0] pullup_next;
  assign pullup_next = (global_pullup_disable_reg ? {PINS{1'b0}}
                       : (pullup_enable_reg & `MASK_HAS_PULLUP & direction_eff
                          & ~analog_pin))
                       | (master_clear_en ? `MASK_PIN_THREE : {PINS{1'b0}});

  // Address phase decode
  wire       addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  wire       rd_take    = addr_phase & ~hwrite;
  wire       wr_take    = addr_phase & hwrite;
  wire [7:0] addr8      = haddr[7:0];
  wire       port_read  = rd_take & (addr8 == `OFF_PORT_PIN_LEVELS);
  wire       port_write = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_PORT_PIN_LEVELS);
  wire       wr_interrupt_control_reg  = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_INTERRUPT_CONTROL);
  wire       wr_dir     = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_PORT_DIRECTION);
  wire       wr_an_low  = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_ANALOG_SELECT_LOW);
  wire       wr_an_high = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_ANALOG_SELECT_HIGH);
  wire       wr_pullup  = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_PULLUP_ENABLE);
  wire       wr_chg_en  = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_CHANGE_IRQ_ENABLE);
  wire       wr_option  = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_OPTION);
  wire       wr_config  = wr_hit(wr_pending_reg, wr_addr_reg, `OFF_CONFIG);

  reg [31:0] read_mux;

  always @* begin
    case (addr8)
      `OFF_PORT_PIN_LEVELS:    read_mux = word6(port_read_value);
      `OFF_PORT_DIRECTION:     read_mux = word6(direction_eff);
      `OFF_ANALOG_SELECT_LOW:  read_mux = {24'h000000, analog_select_low_reg};
      `OFF_ANALOG_SELECT_HIGH: read_mux = {28'h0000000, analog_select_high_reg};
      `OFF_PULLUP_ENABLE:
        read_mux = word6(osc_force(pullup_enable_reg & `MASK_HAS_PULLUP, osc_pins));
      `OFF_CHANGE_IRQ_ENABLE:
        read_mux = word6(osc_force(change_irq_enable_reg, osc_pins));
      `OFF_INTERRUPT_CONTROL:  read_mux = {31'h00000000, change_flag_reg};
      `OFF_OPTION:             read_mux = {31'h00000000, global_pullup_disable_reg};
      `OFF_CONFIG:             read_mux = {30'h00000000, config_reg};
      default:                 read_mux = 32'h00000000;
    endcase
  end

  // Three-stage synchroniser; only stage two reads stage one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      sync3_reg <= 6'h00;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // A level is accepted once stages two and three agree; a one-cycle
  // glitch never makes them agree on the wrong value
  wire [PINS-1:0] sync_agree = ~(sync2_reg ^ sync3_reg);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_level_reg <= 6'h00;
    end else begin
      pin_level_reg <= (pin_level_reg & ~sync_agree)
                     | (sync3_reg & sync_agree);
    end
  end

  // Last-read latch: only power-on clears it, warm resets leave it alone
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_read_reg <= 6'h00;
    end else if (port_read | port_write) begin
      // Samples the same filtered level the bus sees; a change seen in this
      // very cycle is latched and still flagged, as mismatch uses the old latch
      last_read_reg <= port_read_value;
    end
  end

  // Bus slave: zero wait states, read data registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg    <= 8'h00;
      hrdata_reg     <= 32'h00000000;
    end else begin
      wr_pending_reg <= wr_take;
      if (wr_take) begin
        wr_addr_reg <= addr8;
      end
      if (rd_take) begin
        hrdata_reg <= read_mux;
      end
    end
  end

  // The slave never stalls and never answers with an error
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= `HRESP_OKAY;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= `HRESP_OKAY;
    end
  end

  // Output latch; warm resets leave it as it was
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_latch_reg <= `RST_PORT_LATCH;
    end else if (port_write && !warm_reset) begin
      // Whole-word write; bits of analog pins read back 0, so a software
      // read-modify-write will clear their latch bits
      port_latch_reg <= hwdata[PINS-1:0];
    end
  end

  // Warm resets restore the power-on value of direction and select bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_direction_reg <= `RST_PORT_DIRECTION;
    end else if (warm_reset) begin
      port_direction_reg <= `RST_PORT_DIRECTION;
    end else if (wr_dir) begin
      port_direction_reg <= hwdata[PINS-1:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_select_low_reg <= `RST_ANALOG_LOW;
    end else if (warm_reset) begin
      analog_select_low_reg <= `RST_ANALOG_LOW;
    end else if (wr_an_low) begin
      analog_select_low_reg <= hwdata[7:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_select_high_reg <= `RST_ANALOG_HIGH;
    end else if (warm_reset) begin
      analog_select_high_reg <= `RST_ANALOG_HIGH;
    end else if (wr_an_high) begin
      analog_select_high_reg <= hwdata[3:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_enable_reg <= `RST_PULLUP_ENABLE;
    end else if (warm_reset) begin
      pullup_enable_reg <= `RST_PULLUP_ENABLE;
    end else if (wr_pullup) begin
      pullup_enable_reg <= hwdata[PINS-1:0] & `MASK_HAS_PULLUP;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      change_irq_enable_reg <= `RST_CHANGE_IRQ_ENABLE;
    end else if (warm_reset) begin
      change_irq_enable_reg <= `RST_CHANGE_IRQ_ENABLE;
    end else if (wr_chg_en) begin
      change_irq_enable_reg <= hwdata[PINS-1:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_pullup_disable_reg <= `RST_OPTION;
    end else if (warm_reset) begin
      global_pullup_disable_reg <= `RST_OPTION;
    end else if (wr_option) begin
      global_pullup_disable_reg <= hwdata[`OPTION_PULLUP_DIS_BIT];
    end
  end

  // Configuration bits survive warm resets
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_reg <= `RST_CONFIG;
    end else if (wr_config && !warm_reset) begin
      config_reg <= hwdata[1:0];
    end
  end

  // A surviving mismatch sets the flag again straight after a warm reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      change_flag_reg <= 1'b0;
    end else if (warm_reset) begin
      change_flag_reg <= mismatch;
    end else if (mismatch) begin
      // Set wins over a clear in the same cycle
      change_flag_reg <= 1'b1;
    end else if (wr_interrupt_control_reg) begin
      change_flag_reg <= hwdata[`INTERRUPT_CONTROL_REG_CHANGE_FLAG_BIT];
    end
  end

  // Pin drive and pull-ups, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_reg       <= 6'h00;
      pin_oe_reg        <= 6'h00;
      pullup_on_reg     <= 6'h00;
      digital_in_en_reg <= 6'h00;
    end else begin
      pin_out_reg       <= port_latch_reg & ~`MASK_PIN_THREE;
      pin_oe_reg        <= ~direction_eff;
      pullup_on_reg     <= pullup_next;
      digital_in_en_reg <= ~analog_pin;
    end
  end

  // Also follows a mismatch not yet in the flag, so the core wakes
  // one cycle sooner
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= change_flag_reg | mismatch;
    end
  end

  assign hrdata          = hrdata_reg;
  assign hreadyout       = hreadyout_reg;
  assign hresp           = hresp_reg;
  assign pin_out         = pin_out_reg;
  assign pin_oe          = pin_oe_reg;
  assign pullup_on       = pullup_on_reg;
  assign digital_in_en   = digital_in_en_reg;
  assign change_irq_flag = change_flag_reg;
  assign wake_req        = wake_req_reg;

endmodule
`default_nettype wire

// ===== verification/pin_board.sv
// Board model: resolves each pin from driver, external source and pull-up
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pullup_on,
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  output wire logic [5:0] pin_in
);
  // Released pins sit on board pull-downs, so a missing pull-up reads 0
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & pullup_on);
endmodule
`default_nettype wire

// ===== verification/six_bit_port_assertions.sv
// Port-level checks for the six-bit port
`timescale 1ns/1ps
`default_nettype none
module six_bit_port_assertions #(
  parameter PINS = 6
) (
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic            hready,
  input wire logic [31:0]     hrdata,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pullup_on,
  input wire logic [PINS-1:0] digital_in_en,
  input wire logic            change_irq_flag,
  input wire logic            wake_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_any = hsel && hready && htrans[1] && !hwrite;
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or answered with error");
  chk_pin3_input: assert property (!pin_oe[3] && !pin_out[3])
    else $error("pin three driven");
  chk_out_no_pull: assert property ((pin_oe & pullup_on & 6'h37) == 6'h00)
    else $error("pull-up on an output pin");
  chk_analog_no_pull: assert property ((~digital_in_en & pullup_on & 6'h37) == 6'h00)
    else $error("pull-up on an analog pin");
  chk_wake_flag: assert property (change_irq_flag |=> wake_req)
    else $error("flag set without wake request");
  chk_port_upper: assert property (rd_any && haddr[7:0] == 8'h00 |=> hrdata[31:6] == 26'h0)
    else $error("port read upper bits not zero");
  chk_high_upper: assert property (rd_any && haddr[7:0] == 8'h0c |=> hrdata[31:4] == 28'h0)
    else $error("analog high upper bits not zero");
  chk_dir3_one: assert property (rd_any && haddr[7:0] == 8'h04 |=> hrdata[3])
    else $error("direction bit three read 0");
  chk_analog_zero: assert property (rd_any && haddr[7:0] == 8'h00
    |=> (hrdata[5:0] & ~digital_in_en) == 6'h00)
    else $error("analog pin read as 1");
endmodule
bind six_bit_port six_bit_port_assertions #(.PINS(PINS)) six_bit_port_assertions_i (.*);
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the six-bit port
`timescale 1ns/1ps
`default_nettype none
`include "six_bit_port_defs.vh"
module testbench;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        warm_reset = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [5:0]  ext_val = 6'h0;
  logic [5:0]  ext_en = 6'h0;
  logic [31:0] rdat;
  wire         hready;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [5:0]  pin_in, pin_out, pin_oe, pullup_on, digital_in_en;
  wire         change_irq_flag, wake_req;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  six_bit_port six_bit_port_i (.*);
  pin_board pin_board_i (.*);
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
    idle(3);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk_word(rdat, exp);
  endtask
  task automatic t_reset;
    rd_chk(`OFF_PORT_DIRECTION, 32'h3f);
    rd_chk(`OFF_ANALOG_SELECT_LOW, 32'hff);
    rd_chk(`OFF_ANALOG_SELECT_HIGH, 32'hf);
    rd_chk(`OFF_PULLUP_ENABLE, 32'h37);
    rd_chk(`OFF_CHANGE_IRQ_ENABLE, 32'h0);
    rd_chk(`OFF_OPTION, 32'h1);
    rd_chk(`OFF_PORT_PIN_LEVELS, 32'h0);
    chk_pins(pullup_on, 6'h0);
    chk_pins(digital_in_en, 6'h28);
    wr(8'h40, 32'hff);
    rd_chk(8'h40, 32'h0);
  endtask
  task automatic t_drive;
    wr(`OFF_ANALOG_SELECT_LOW, 32'h0);
    wr(`OFF_OPTION, 32'h0);
    wr(`OFF_PORT_DIRECTION, 32'h0);
    wr(`OFF_PORT_PIN_LEVELS, 32'h3f);
    ext_en <= 6'h08;
    ext_val <= 6'h08;
    idle(6);
    chk_pins(pin_oe, 6'h37);
    chk_pins(pin_out, 6'h37);
    chk_pins(pullup_on, 6'h0);
    rd_chk(`OFF_PORT_DIRECTION, 32'h08);
    rd_chk(`OFF_PORT_PIN_LEVELS, 32'h3f);
    wr(`OFF_ANALOG_SELECT_LOW, 32'h1);
    chk_pins(pin_oe & pin_out, 6'h37);
    rd_chk(`OFF_PORT_PIN_LEVELS, 32'h3e);
    wr(`OFF_PORT_PIN_LEVELS, rdat);
    chk_pins(pin_out, 6'h36);
  endtask
  task automatic t_pull;
    wr(`OFF_ANALOG_SELECT_LOW, 32'h0);
    wr(`OFF_PORT_DIRECTION, 32'h3f);
    ext_en <= 6'h0;
    wr(`OFF_CONFIG, 32'h1);
    idle(4);
    chk_pins(pullup_on, 6'h3f);
    rd_chk(`OFF_PORT_PIN_LEVELS, 32'h37);
    wr(`OFF_PULLUP_ENABLE, 32'h1f);
    rd_chk(`OFF_PULLUP_ENABLE, 32'h17);
    chk_pins(pullup_on, 6'h1f);
    wr(`OFF_PULLUP_ENABLE, 32'h37);
    wr(`OFF_ANALOG_SELECT_LOW, 32'h2);
    chk_pins(pullup_on, 6'h3d);
    wr(`OFF_OPTION, 32'h1);
    chk_pins(pullup_on, 6'h08);
    wr(`OFF_CONFIG, 32'h0);
    chk_pins(pullup_on, 6'h0);
  endtask
  task automatic t_osc;
    wr(`OFF_CONFIG, 32'h2);
    wr(`OFF_PORT_DIRECTION, 32'h0);
    rd_chk(`OFF_PORT_DIRECTION, 32'h38);
    chk_pins(pin_oe, 6'h07);
    wr(`OFF_CONFIG, 32'h0);
    wr(`OFF_PORT_DIRECTION, 32'h3f);
  endtask
  task automatic t_change;
    ext_en <= 6'h3f;
    ext_val <= 6'h0;
    wr(`OFF_ANALOG_SELECT_LOW, 32'h0);
    rd_chk(`OFF_PORT_PIN_LEVELS, 32'h0);
    wr(`OFF_CHANGE_IRQ_ENABLE, 32'h1);
    chk_pins({4'h0, wake_req, change_irq_flag}, 6'h0);
    ext_val <= 6'h1;
    idle(8);
    chk_pins({4'h0, wake_req, change_irq_flag}, 6'h3);
    wr(`OFF_INTERRUPT_CONTROL, 32'h0);
    chk_pins({4'h0, wake_req, change_irq_flag}, 6'h3);
    rd_chk(`OFF_PORT_PIN_LEVELS, 32'h1);
    wr(`OFF_INTERRUPT_CONTROL, 32'h0);
    chk_pins({4'h0, wake_req, change_irq_flag}, 6'h0);
    ext_val <= 6'h0;
    idle(8);
    warm_reset <= 1'h1;
    idle(1);
    warm_reset <= 1'h0;
    wr(`OFF_INTERRUPT_CONTROL, 32'h0);
    chk_pins({4'h0, wake_req, change_irq_flag}, 6'h0);
    wr(`OFF_ANALOG_SELECT_LOW, 32'h0);
    wr(`OFF_CHANGE_IRQ_ENABLE, 32'h1);
    idle(2);
    chk_pins({4'h0, wake_req, change_irq_flag}, 6'h3);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset;
    t_drive;
    t_pull;
    t_osc;
    t_change;
    test_done;
  end
endmodule
`default_nettype wire
